/* hdl/calib_pkg.sv */
// Register map and constants of the phase C calibration register bank
package calib_pkg;

    // Data and address widths of the register port
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Number of multipoint correction sets and width of their index
    localparam int NUM_POINTS = 5;
    localparam int RANGE_W = $clog2(NUM_POINTS);
    localparam int REG_COUNT = 18;

    // Every calibration word comes out of reset cleared
    localparam logic [DATA_W-1:0] CAL_RESET = 32'h00000000;
    localparam logic [RANGE_W-1:0] RANGE_FIRST = 3'h0;
    localparam logic [RANGE_W-1:0] RANGE_STEP = 3'h1;

    // Word offsets as seen on the register port
    localparam logic [ADDR_W-1:0] OFF_B_VAR_OS = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_B_FVAR_OS = 8'h32;
    localparam logic [ADDR_W-1:0] OFF_C_IGAIN = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_C_MPG0 = 8'h41;
    localparam logic [ADDR_W-1:0] OFF_C_MPG1 = 8'h42;
    localparam logic [ADDR_W-1:0] OFF_C_MPG2 = 8'h43;
    localparam logic [ADDR_W-1:0] OFF_C_MPG3 = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_C_MPG4 = 8'h45;
    localparam logic [ADDR_W-1:0] OFF_C_PC0 = 8'h46;
    localparam logic [ADDR_W-1:0] OFF_C_PC1 = 8'h47;
    localparam logic [ADDR_W-1:0] OFF_C_PC2 = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_C_PC3 = 8'h49;
    localparam logic [ADDR_W-1:0] OFF_C_PC4 = 8'h4a;
    localparam logic [ADDR_W-1:0] OFF_C_VGAIN = 8'h4b;
    localparam logic [ADDR_W-1:0] OFF_C_IRMS_OS = 8'h4c;
    localparam logic [ADDR_W-1:0] OFF_C_VRMS_OS = 8'h4d;
    localparam logic [ADDR_W-1:0] OFF_C_PGAIN = 8'h4e;
    localparam logic [ADDR_W-1:0] OFF_C_WATT_OS = 8'h4f;

    // Storage slot of each register
    localparam int IDX_B_VAR_OS = 0;
    localparam int IDX_B_FVAR_OS = 1;
    localparam int IDX_C_IGAIN = 2;
    localparam int IDX_C_MPG0 = 3;
    localparam int IDX_C_PC0 = 8;
    localparam int IDX_C_VGAIN = 13;
    localparam int IDX_C_IRMS_OS = 14;
    localparam int IDX_C_VRMS_OS = 15;
    localparam int IDX_C_PGAIN = 16;
    localparam int IDX_C_WATT_OS = 17;

    // Offset of each storage slot, in slot order
    localparam logic [ADDR_W-1:0] REG_ADDR [REG_COUNT] = '{
        OFF_B_VAR_OS, OFF_B_FVAR_OS, OFF_C_IGAIN,
        OFF_C_MPG0, OFF_C_MPG1, OFF_C_MPG2, OFF_C_MPG3, OFF_C_MPG4,
        OFF_C_PC0, OFF_C_PC1, OFF_C_PC2, OFF_C_PC3, OFF_C_PC4,
        OFF_C_VGAIN, OFF_C_IRMS_OS, OFF_C_VRMS_OS, OFF_C_PGAIN,
        OFF_C_WATT_OS
    };

endpackage

/* hdl/range_selector.sv */
// Hysteretic current range selector for multipoint correction
module range_selector
    import calib_pkg::*;
#(
    parameter int POINTS = NUM_POINTS,
    parameter int WIDTH = DATA_W
) (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Selection control
    input wire logic multipoint_enable_i,
    input wire logic [WIDTH-1:0] current_rms_i,
    input wire logic [POINTS*WIDTH-1:0] low_thr_i,
    input wire logic [POINTS*WIDTH-1:0] high_thr_i,
    // Selected range
    output logic [RANGE_W-1:0] range_index_o
);

    logic [WIDTH-1:0] low_thr [POINTS];
    logic [WIDTH-1:0] high_thr [POINTS];

    // Split the flat threshold buses into one word per range
    for (genvar k = 0; k < POINTS; k++) begin : g_thr
        assign low_thr[k] = low_thr_i[k*WIDTH +: WIDTH];
        assign high_thr[k] = high_thr_i[k*WIDTH +: WIDTH];
    end

    // One step per cycle; the band between low and high holds the range
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            range_index_o <= RANGE_FIRST;
        end else if (ce_i) begin
            if (!multipoint_enable_i) begin
                range_index_o <= RANGE_FIRST;
            end else if (int'(range_index_o) < POINTS - 1 &&
                         current_rms_i > high_thr[range_index_o]) begin
                range_index_o <= range_index_o + RANGE_STEP;
            end else if (range_index_o != RANGE_FIRST &&
                         current_rms_i < low_thr[range_index_o]) begin
                range_index_o <= range_index_o - RANGE_STEP;
            end
        end
    end

    a_band_holds: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        multipoint_enable_i && current_rms_i >= low_thr[range_index_o] &&
        current_rms_i <= high_thr[range_index_o] |=> $stable(range_index_o))
        else $error("range index moved inside its hysteresis band");

    a_single_step: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        multipoint_enable_i && ce_i ##1 range_index_o != $past(range_index_o)
        |-> range_index_o == $past(range_index_o) + RANGE_STEP ||
            range_index_o == $past(range_index_o) - RANGE_STEP)
        else $error("range index jumped by more than one");

endmodule

/* hdl/phase_c_calibration_registers.sv */
// Phase C calibration register bank with multipoint correction select
module phase_c_calibration_registers
    import calib_pkg::*;
(
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic ce_i,

    // Register port
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic [DATA_W-1:0] write_data_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [DATA_W-1:0] read_data_o,

    // Multipoint selection inputs from the metrology core
    input wire logic multipoint_enable_i,
    input wire logic [DATA_W-1:0] phase_c_current_rms_value_i,
    input wire logic [NUM_POINTS*DATA_W-1:0] range_low_thresholds_i,
    input wire logic [NUM_POINTS*DATA_W-1:0] range_high_thresholds_i,

    // Phase B reactive offsets
    output logic [DATA_W-1:0] phase_b_reactive_offset_o,
    output logic [DATA_W-1:0] phase_b_fund_reactive_offset_o,

    // Phase C channel gains and rms offsets
    output logic [DATA_W-1:0] phase_c_current_gain_o,
    output logic [DATA_W-1:0] phase_c_voltage_gain_o,
    output logic [DATA_W-1:0] phase_c_current_rms_offset_o,
    output logic [DATA_W-1:0] phase_c_voltage_rms_offset_o,

    // Phase C power corrections
    output logic [DATA_W-1:0] phase_c_active_power_gain_o,
    output logic [DATA_W-1:0] phase_c_apparent_power_gain_o,
    output logic [DATA_W-1:0] phase_c_reactive_power_gain_o,
    output logic [DATA_W-1:0] phase_c_fund_reactive_power_gain_o,
    output logic [DATA_W-1:0] phase_c_active_power_offset_o,

    // Multipoint selection results
    output logic multipoint_active_o,
    output logic [RANGE_W-1:0] range_index_o,
    output logic [DATA_W-1:0] multipoint_gain_o,
    output logic [DATA_W-1:0] phase_correction_o
);

    logic [DATA_W-1:0] cal_reg [REG_COUNT];
    logic [REG_COUNT-1:0] hit;
    logic [DATA_W-1:0] next_read_data;
    logic [DATA_W-1:0] next_multipoint_gain;
    logic [DATA_W-1:0] next_phase_correction;
    logic [RANGE_W-1:0] range_index;

    // Address decode, one comparator per slot
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_decode
        assign hit[i] = (address_i == REG_ADDR[i]);
    end

    // Storage: one word per slot, written only on a matching strobe
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_store
        always_ff @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cal_reg[i] <= CAL_RESET;
            end else if (ce_i && write_i && hit[i]) begin
                cal_reg[i] <= write_data_i;
            end
        end
    end

    // Read mux; an unmapped offset answers with zero
    always_comb begin
        next_read_data = CAL_RESET;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (hit[i]) begin
                next_read_data = cal_reg[i];
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_data_o <= CAL_RESET;
        end else if (ce_i) begin
            read_data_o <= read_i ? next_read_data : CAL_RESET;
        end
    end

    // Fixed corrections go straight out of their storage flops
    assign phase_b_reactive_offset_o = cal_reg[IDX_B_VAR_OS];
    assign phase_b_fund_reactive_offset_o = cal_reg[IDX_B_FVAR_OS];
    assign phase_c_current_gain_o = cal_reg[IDX_C_IGAIN];
    assign phase_c_voltage_gain_o = cal_reg[IDX_C_VGAIN];
    assign phase_c_current_rms_offset_o = cal_reg[IDX_C_IRMS_OS];
    assign phase_c_voltage_rms_offset_o = cal_reg[IDX_C_VRMS_OS];
    assign phase_c_active_power_offset_o = cal_reg[IDX_C_WATT_OS];

    // One power gain word fans out to the four power calculations
    assign phase_c_active_power_gain_o = cal_reg[IDX_C_PGAIN];
    assign phase_c_apparent_power_gain_o = cal_reg[IDX_C_PGAIN];
    assign phase_c_reactive_power_gain_o = cal_reg[IDX_C_PGAIN];
    assign phase_c_fund_reactive_power_gain_o = cal_reg[IDX_C_PGAIN];

    // Range tracking lives in its own block so the band logic stays apart
    range_selector #(
        .POINTS(NUM_POINTS),
        .WIDTH(DATA_W)
    ) u_range (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .multipoint_enable_i(multipoint_enable_i),
        .current_rms_i(phase_c_current_rms_value_i),
        .low_thr_i(range_low_thresholds_i),
        .high_thr_i(range_high_thresholds_i),
        .range_index_o(range_index)
    );

    assign range_index_o = range_index;

    // Pick the correction words of the current range
    always_comb begin
        next_multipoint_gain = cal_reg[IDX_C_MPG0 + int'(range_index)];
        next_phase_correction = cal_reg[IDX_C_PC0];
        if (multipoint_enable_i) begin
            next_phase_correction =
                cal_reg[IDX_C_PC0 + int'(range_index)];
        end
    end

    // Registered so a range change switches both words on one edge, but on disable the phase word
    // reaches the first set one cycle before the gain; costs one cycle of lag after a range change
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            multipoint_gain_o <= CAL_RESET;
            phase_correction_o <= CAL_RESET;
            multipoint_active_o <= 1'b0;
        end else if (ce_i) begin
            multipoint_gain_o <= next_multipoint_gain;
            phase_correction_o <= next_phase_correction;
            multipoint_active_o <= multipoint_enable_i;
        end
    end

    // Checks run on the block clock and pause during reset
    default clocking cb @(posedge clock_i);
    endclocking

    default disable iff (!reset_n_i);

    a_write_readback: assert property (
        (ce_i && write_i) ##1 (ce_i && read_i &&
        address_i == $past(address_i) && hit != '0)
        |=> read_data_o == $past(write_data_i, 2))
        else $error("read did not return the word just written");

    a_unmapped_zero: assert property (
        ce_i && read_i && hit == '0 |=> read_data_o == CAL_RESET)
        else $error("unmapped read did not return zero");

    a_current_gain: assert property (
        ce_i && write_i && address_i == OFF_C_IGAIN
        |=> phase_c_current_gain_o == $past(write_data_i))
        else $error("current gain not updated by its write");

    a_voltage_gain: assert property (
        ce_i && write_i && address_i == OFF_C_VGAIN
        |=> phase_c_voltage_gain_o == $past(write_data_i))
        else $error("voltage gain not updated by its write");

    a_irms_offset: assert property (
        !(write_i && address_i == OFF_C_IRMS_OS) [*2]
        |-> $stable(phase_c_current_rms_offset_o))
        else $error("current rms offset changed without a write");

    a_vrms_offset: assert property (
        ce_i && write_i && address_i == OFF_C_VRMS_OS
        |=> phase_c_voltage_rms_offset_o == $past(write_data_i))
        else $error("voltage rms offset not updated by its write");

    a_watt_offset: assert property (
        ce_i && write_i && address_i == OFF_C_WATT_OS
        |=> phase_c_active_power_offset_o == $past(write_data_i))
        else $error("active power offset not updated by its write");

    a_b_var_offset: assert property (
        ce_i && write_i && address_i == OFF_B_VAR_OS ##1 !write_i
        |=> phase_b_reactive_offset_o == $past(write_data_i, 2))
        else $error("phase b reactive offset lost its write");

    a_b_fvar_offset: assert property (
        ce_i && write_i && address_i == OFF_B_FVAR_OS
        |=> phase_b_fund_reactive_offset_o == $past(write_data_i) &&
            phase_b_reactive_offset_o == $past(phase_b_reactive_offset_o))
        else $error("phase b fundamental offset write went astray");

    a_power_fanout: assert property (
        ce_i && write_i && address_i == OFF_C_PGAIN
        |=> phase_c_active_power_gain_o == $past(write_data_i) &&
            phase_c_apparent_power_gain_o == $past(write_data_i) &&
            phase_c_reactive_power_gain_o == $past(write_data_i) &&
            phase_c_fund_reactive_power_gain_o == $past(write_data_i))
        else $error("power gain not applied to all four powers");

    a_gain_by_range: assert property (
        ce_i && multipoint_enable_i
        |=> multipoint_active_o &&
            multipoint_gain_o ==
            $past(cal_reg[IDX_C_MPG0 + int'(range_index)]))
        else $error("multipoint gain does not follow the range");

    a_phase_first_only: assert property (
        (ce_i && !multipoint_enable_i) [*2]
        |=> range_index_o == RANGE_FIRST &&
            phase_correction_o == $past(cal_reg[IDX_C_PC0]))
        else $error("phase correction not the first set when disabled");

    a_phase_by_range: assert property (
        ce_i && multipoint_enable_i
        |=> phase_correction_o ==
            $past(cal_reg[IDX_C_PC0 + int'(range_index)]))
        else $error("phase correction does not follow the range");

    // With the enable low nothing may move, read data included, so a
    // stalled host never sees a word change under it
    a_freeze_read: assert property (
        !ce_i
        |=> $stable(read_data_o))
        else $error("read data moved with the enable low");

    a_freeze_index: assert property (
        !ce_i
        |=> $stable(range_index_o))
        else $error("range index moved with the enable low");

    a_freeze_phase: assert property (
        !ce_i
        |=> $stable(phase_correction_o))
        else $error("phase correction moved with the enable low");

    a_freeze_gain_sel: assert property (
        !ce_i
        |=> $stable(multipoint_gain_o))
        else $error("multipoint gain moved with the enable low");

    a_freeze_active: assert property (
        !ce_i
        |=> $stable(multipoint_active_o))
        else $error("multipoint flag moved with the enable low");

    // Read data shows the stored word for one cycle, zero otherwise
    a_read_idle_zero: assert property (
        ce_i && !read_i
        |=> read_data_o == CAL_RESET)
        else $error("read data not zero in a cycle without a read");

    a_read_igain: assert property (
        ce_i && read_i && address_i == OFF_C_IGAIN
        |=> read_data_o == $past(phase_c_current_gain_o))
        else $error("current gain read back differs from its output");

    a_read_vgain: assert property (
        ce_i && read_i && address_i == OFF_C_VGAIN
        |=> read_data_o == $past(phase_c_voltage_gain_o))
        else $error("voltage gain read back differs from its output");

    a_read_pgain: assert property (
        ce_i && read_i && address_i == OFF_C_PGAIN
        |=> read_data_o == $past(phase_c_active_power_gain_o))
        else $error("power gain read back differs from its output");

    a_read_watt_os: assert property (
        ce_i && read_i && address_i == OFF_C_WATT_OS
        |=> read_data_o == $past(phase_c_active_power_offset_o))
        else $error("active power offset read back differs");

    // A word moves only on a write to its own offset; a decode slip
    // would otherwise corrupt a neighbour silently
    a_hold_igain: assert property (
        !(ce_i && write_i && address_i == OFF_C_IGAIN)
        |=> $stable(phase_c_current_gain_o))
        else $error("current gain changed without its write");

    a_hold_vgain: assert property (
        !(ce_i && write_i && address_i == OFF_C_VGAIN)
        |=> $stable(phase_c_voltage_gain_o))
        else $error("voltage gain changed without its write");

    a_hold_vrms: assert property (
        !(ce_i && write_i && address_i == OFF_C_VRMS_OS)
        |=> $stable(phase_c_voltage_rms_offset_o))
        else $error("voltage rms offset changed without its write");

    a_hold_watt: assert property (
        !(ce_i && write_i && address_i == OFF_C_WATT_OS)
        |=> $stable(phase_c_active_power_offset_o))
        else $error("active power offset changed without its write");

    a_hold_b_var: assert property (
        !(ce_i && write_i && address_i == OFF_B_VAR_OS)
        |=> $stable(phase_b_reactive_offset_o))
        else $error("phase b reactive offset changed without its write");

    a_hold_b_fvar: assert property (
        !(ce_i && write_i && address_i == OFF_B_FVAR_OS)
        |=> $stable(phase_b_fund_reactive_offset_o))
        else $error("phase b fundamental offset changed without write");

    a_hold_pgain: assert property (
        !(ce_i && write_i && address_i == OFF_C_PGAIN)
        |=> $stable(phase_c_reactive_power_gain_o))
        else $error("power gain changed without its write");

    // Selection bookkeeping, and the current rms offset write
    a_active_follows: assert property (
        ce_i
        |=> multipoint_active_o == $past(multipoint_enable_i))
        else $error("multipoint flag does not follow the enable");

    a_index_cleared: assert property (
        ce_i && !multipoint_enable_i
        |=> range_index_o == RANGE_FIRST)
        else $error("range index not cleared while disabled");

    a_index_bound: assert property (
        1'b1
        |-> int'(range_index_o) < NUM_POINTS)
        else $error("range index beyond the last correction set");

    a_irms_write: assert property (
        ce_i && write_i && address_i == OFF_C_IRMS_OS
        |=> phase_c_current_rms_offset_o == $past(write_data_i))
        else $error("current rms offset not updated by its write");

endmodule

/* tb/tb_phase_c_calibration_registers.sv */
// Self-checking bench for the phase C calibration register bank
module tb_phase_c_calibration_registers
    import calib_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i, reset_n_i, ce_i, write_i, read_i, multipoint_enable_i;
    logic [ADDR_W-1:0] address_i;
    logic [DATA_W-1:0] write_data_i, read_data_o, phase_c_current_rms_value_i;
    logic [NUM_POINTS*DATA_W-1:0] range_low_thresholds_i;
    logic [NUM_POINTS*DATA_W-1:0] range_high_thresholds_i;
    logic [DATA_W-1:0] b_var_os, b_fvar_os, c_igain, c_vgain, c_irms_os;
    logic [DATA_W-1:0] c_vrms_os, c_wgain, c_vagain, c_vargain, c_fvargain;
    logic [DATA_W-1:0] c_watt_os, mp_gain, phase_corr, v;
    logic mp_active, en_s, en_prev;
    logic [RANGE_W-1:0] range_index, exp_idx, prev_idx;
    logic [DATA_W-1:0] mem [REG_COUNT];
    logic [DATA_W-1:0] rms_s;
    int failures = 0;
    int n_compared = 0;
    int seed = 32'hfbd4;

    phase_c_calibration_registers u_phase_c_calibration_registers (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .address_i(address_i), .write_data_i(write_data_i),
        .write_i(write_i), .read_i(read_i), .read_data_o(read_data_o),
        .multipoint_enable_i(multipoint_enable_i),
        .phase_c_current_rms_value_i(phase_c_current_rms_value_i),
        .range_low_thresholds_i(range_low_thresholds_i),
        .range_high_thresholds_i(range_high_thresholds_i),
        .phase_b_reactive_offset_o(b_var_os),
        .phase_b_fund_reactive_offset_o(b_fvar_os),
        .phase_c_current_gain_o(c_igain), .phase_c_voltage_gain_o(c_vgain),
        .phase_c_current_rms_offset_o(c_irms_os),
        .phase_c_voltage_rms_offset_o(c_vrms_os),
        .phase_c_active_power_gain_o(c_wgain),
        .phase_c_apparent_power_gain_o(c_vagain),
        .phase_c_reactive_power_gain_o(c_vargain),
        .phase_c_fund_reactive_power_gain_o(c_fvargain),
        .phase_c_active_power_offset_o(c_watt_os),
        .multipoint_active_o(mp_active), .range_index_o(range_index),
        .multipoint_gain_o(mp_gain), .phase_correction_o(phase_corr)
    );

    // Free-running 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Threshold ladder: high of one range overlaps low of the next
    function automatic logic [DATA_W-1:0] thr_lo(input int k);
        return 32'(1000 * k);
    endfunction
    function automatic logic [DATA_W-1:0] thr_hi(input int k);
        return 32'(1000 * (k + 1) + 200);
    endfunction

    // Expected next range, strict unsigned compares, one step at most
    function automatic logic [RANGE_W-1:0] next_range(
        input logic [RANGE_W-1:0] k, input logic [DATA_W-1:0] r);
        if (k < NUM_POINTS - 1 && r > thr_hi(k)) return k + RANGE_STEP;
        if (k > 0 && r < thr_lo(k)) return k - RANGE_STEP;
        return k;
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Strobe stays high so writes can follow each other with no gap
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_i);
        address_i <= a;
        write_data_i <= d;
        write_i <= 1'b1;
        read_i <= 1'b0;
    endtask
    task automatic bus_idle;
        @(posedge clock_i);
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    // Read data is taken in the one cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock_i);
        address_i <= a;
        read_i <= 1'b1;
        write_i <= 1'b0;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = read_data_o;
    endtask

    // Every direct output against the bench's copy of the map
    task automatic check_direct;
        check(b_var_os, mem[IDX_B_VAR_OS]);
        check(b_fvar_os, mem[IDX_B_FVAR_OS]);
        check(c_igain, mem[IDX_C_IGAIN]);
        check(c_vgain, mem[IDX_C_VGAIN]);
        check(c_irms_os, mem[IDX_C_IRMS_OS]);
        check(c_vrms_os, mem[IDX_C_VRMS_OS]);
        check(c_wgain, mem[IDX_C_PGAIN]);
        check(c_vagain, mem[IDX_C_PGAIN]);
        check(c_vargain, mem[IDX_C_PGAIN]);
        check(c_fvargain, mem[IDX_C_PGAIN]);
        check(c_watt_os, mem[IDX_C_WATT_OS]);
    endtask

    task automatic read_all;
        for (int i = 0; i < REG_COUNT; i++) begin
            rd(REG_ADDR[i], v);
            check(v, mem[i]);
        end
    endtask

    // Hang guard well beyond the longest sequence
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        ce_i = 1'b1;
        address_i = '0;
        write_data_i = '0;
        write_i = 1'b0;
        read_i = 1'b0;
        multipoint_enable_i = 1'b0;
        phase_c_current_rms_value_i = '0;
        for (int k = 0; k < NUM_POINTS; k++) begin
            range_low_thresholds_i[DATA_W*k +: DATA_W] = thr_lo(k);
            range_high_thresholds_i[DATA_W*k +: DATA_W] = thr_hi(k);
        end
        foreach (mem[i]) mem[i] = CAL_RESET;
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        check_direct();
        read_all();
        $display("test reset_values done");
        // Back-to-back random writes, then an unmapped write and read
        foreach (mem[i]) mem[i] = $random(seed);
        for (int i = 0; i < REG_COUNT; i++) wr(REG_ADDR[i], mem[i]);
        wr(8'h31, $random(seed));
        rd(8'h31, v);
        check(v, CAL_RESET);
        @(posedge clock_i);
        #1 check(read_data_o, CAL_RESET);
        check_direct();
        read_all();
        $display("test write_readback done");
        // A write with the clock enable low must leave storage alone
        @(posedge clock_i);
        ce_i <= 1'b0;
        wr(OFF_C_VGAIN, ~mem[IDX_C_VGAIN]);
        bus_idle();
        @(posedge clock_i);
        ce_i <= 1'b1;
        #1 check(c_vgain, mem[IDX_C_VGAIN]);
        $display("test clock_enable done");
        // Random rms walk with boundary hits; disabled spans every 50
        repeat (2) @(posedge clock_i);
        exp_idx = RANGE_FIRST;
        en_prev = 1'b0;
        for (int n = 0; n < 400; n++) begin
            @(posedge clock_i);
            en_s = multipoint_enable_i;
            rms_s = phase_c_current_rms_value_i;
            prev_idx = exp_idx;
            exp_idx = en_s ? next_range(exp_idx, rms_s) : RANGE_FIRST;
            multipoint_enable_i <= (n % 50) >= 6;
            case (n % 8)
                1: phase_c_current_rms_value_i <= thr_hi(exp_idx);
                2: phase_c_current_rms_value_i <= thr_lo(exp_idx);
                3: phase_c_current_rms_value_i <= 32'hffffffff;
                7: phase_c_current_rms_value_i <= 32'h00000000;
                default: phase_c_current_rms_value_i <=
                    32'($unsigned($random(seed)) % 6000);
            endcase
            #1;
            check(range_index, exp_idx);
            check(mp_active, en_s);
            check(mp_gain, mem[IDX_C_MPG0 + prev_idx]);
            // Phase word follows the enable the design sampled this edge
            v = en_s ? mem[IDX_C_PC0 + prev_idx] : mem[IDX_C_PC0];
            check(phase_corr, v);
            en_prev = en_s;
        end
        $display("test multipoint_select done");
        // Second reset in mid-run clears every word again
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1 check(range_index, RANGE_FIRST);
        reset_n_i <= 1'b1;
        foreach (mem[i]) mem[i] = CAL_RESET;
        check_direct();
        read_all();
        $display("test second_reset done");
        print_verdict();
    end
endmodule
